// ==== hw/rmc_mailbox.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"
module rmc_mailbox
	import rmc_pkg::*;
#(
	parameter int SEC_CYCLES = `RMC_CLK_HZ
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic relationship_info_en,
	input wire logic event_valid,
	input wire logic event_offline,
	input wire rmc_word_t event_handle,
	input wire logic [7:0] event_reason,
	input wire logic cmd_valid,
	input wire rmc_word_t cmd_id,
	input wire rmc_word_t cmd_code,
	input wire rmc_word_t cmd_data,
	input wire logic conn_open,
	input wire logic conn_request,
	input wire logic mbx_ready,
	output logic event_ready,
	output logic cmd_ready,
	output logic mbx_valid,
	output logic [3:0] mbx_index,
	output rmc_word_t mbx_word,
	output logic mbx_last,
	output logic server_enabled,
	output rmc_word_t timeout_sec,
	output logic conn_close
);
	rmc_state_e state_ff, nxt_state;
	logic [4:0] idx_ff, nxt_idx;
	rmc_word_t hdr_ff [0:16];
	rmc_word_t nxt_hdr [0:16];
	logic [4:0] len_ff, nxt_len;
	rmc_word_t tmo_ff, nxt_tmo;
	logic srv_ff, nxt_srv;
	logic evr_ff, nxt_evr, cmr_ff, nxt_cmr;
	logic valid_ff, nxt_valid;
	rmc_word_t word_ff, nxt_word;
	logic last_ff, nxt_last;
	logic sec_tick;
	logic close_w;
	logic tmo_ok;

	// Seconds reference for the idle timer.
	rmc_sec_tick #(.CYCLES(SEC_CYCLES)) u_tick (
		.clock(clock),
		.reset_n(reset_n),
		.tick(sec_tick)
	);

	// Per-connection idle supervision with the live timeout setting.
	rmc_idle_timer u_idle (
		.clock(clock),
		.reset_n(reset_n),
		.sec_tick(sec_tick),
		.conn_open(conn_open && srv_ff),
		.conn_request(conn_request),
		.timeout_sec(tmo_ff),
		.conn_close(close_w)
	);

	// Values 1 to 9 are not legal timeouts.
	assign tmo_ok = (cmd_data == `RMC_ZERO_WORD) || (cmd_data >= `RMC_TMO_MIN);

	// Message builder. Commands take priority over notices so that a
	// host stalled in initialization is answered before events drain.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_len = len_ff;
		nxt_tmo = tmo_ff;
		nxt_srv = srv_ff;
		nxt_evr = 1'b0;
		nxt_cmr = 1'b0;
		for (int i = 0; i < 17; i++)
			nxt_hdr[i] = hdr_ff[i];
		unique case (state_ff)
			RMC_IDLE:
			begin
				if (cmd_valid && !cmr_ff)
				begin
					nxt_cmr = 1'b1;
					for (int i = 0; i < 17; i++)
						nxt_hdr[i] = `RMC_ZERO_WORD;
					nxt_hdr[0] = cmd_id;
					nxt_hdr[1] = `RMC_INFO_RSP;
					nxt_hdr[2] = cmd_code;
					nxt_hdr[4] = `RMC_FRAME_ONE;
					nxt_hdr[5] = `RMC_FRAME_ONE;
					nxt_len = 5'd16;
					if (cmd_code == `RMC_CMD_TIMEOUT)
					begin
						nxt_hdr[3] = `RMC_SIZE_TIMEOUT;
						nxt_hdr[16] = cmd_data;
						nxt_len = 5'd17;
						if (tmo_ok)
							nxt_tmo = cmd_data;
						else
							nxt_hdr[1] = `RMC_INFO_ERR;
					end
					else if (cmd_code == `RMC_CMD_DISABLE)
						nxt_srv = 1'b0;
					else
						nxt_hdr[1] = `RMC_INFO_ERR;
					nxt_idx = 5'd0;
					nxt_state = RMC_SEND;
				end
				else if (event_valid && !evr_ff)
				begin
					nxt_evr = 1'b1;
					if (relationship_info_en)
					begin
						for (int i = 0; i < 17; i++)
							nxt_hdr[i] = `RMC_ZERO_WORD;
						nxt_hdr[1] = `RMC_INFO_CMD;
						nxt_hdr[2] = event_offline ? `RMC_CMD_OFFLINE : `RMC_CMD_ABORT;
						nxt_hdr[4] = `RMC_FRAME_ONE;
						nxt_hdr[5] = `RMC_FRAME_ONE;
						nxt_hdr[8] = event_handle;
						nxt_hdr[9] = {8'h00, event_reason};
						nxt_len = 5'd16;
						nxt_idx = 5'd0;
						nxt_state = RMC_SEND;
					end
				end
			end
			RMC_SEND:
			begin
				if (mbx_ready)
				begin
					if (idx_ff + 5'd1 >= len_ff)
						nxt_state = RMC_WAIT;
					else
						nxt_idx = idx_ff + 5'd1;
				end
			end
			RMC_WAIT:
				nxt_state = RMC_IDLE;
			default:
				nxt_state = RMC_IDLE;
		endcase
	end

	// Output word selection. The word index is five bits wide so that the
	// echoed timeout value (word 16) can be addressed at all.
	always_comb
	begin
		nxt_valid = (nxt_state == RMC_SEND);
		nxt_word = hdr_ff[nxt_idx];
		if (state_ff != RMC_SEND)
			nxt_word = nxt_hdr[0];
		nxt_last = (nxt_state == RMC_SEND) && (nxt_idx + 5'd1 == nxt_len);
	end

	// Registers only.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= RMC_IDLE;
			idx_ff <= 4'h0;
			len_ff <= 5'd0;
			tmo_ff <= `RMC_TMO_DEFAULT;
			srv_ff <= 1'b1;
			evr_ff <= 1'b0;
			cmr_ff <= 1'b0;
			valid_ff <= 1'b0;
			word_ff <= 16'h0000;
			last_ff <= 1'b0;
			for (int i = 0; i < 17; i++)
				hdr_ff[i] <= 16'h0000;
		end
		else
		begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			len_ff <= nxt_len;
			tmo_ff <= nxt_tmo;
			srv_ff <= nxt_srv;
			evr_ff <= nxt_evr;
			cmr_ff <= nxt_cmr;
			valid_ff <= nxt_valid;
			word_ff <= nxt_word;
			last_ff <= nxt_last;
			for (int i = 0; i < 17; i++)
				hdr_ff[i] <= nxt_hdr[i];
		end
	end

	// Index output moves with the word it numbers; word 16 wraps to index 0.
	logic [3:0] oidx_ff;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			oidx_ff <= 4'h0;
		else
			oidx_ff <= (nxt_state == RMC_SEND) ? nxt_idx[3:0] : 4'h0;
	end

	logic close_ff;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			close_ff <= 1'b0;
		else
			close_ff <= close_w;
	end

	assign event_ready = evr_ff;
	assign cmd_ready = cmr_ff;
	assign mbx_valid = valid_ff;
	assign mbx_index = oidx_ff;
	assign mbx_word = word_ff;
	assign mbx_last = last_ff;
	assign server_enabled = srv_ff;
	assign timeout_sec = tmo_ff;
	assign conn_close = close_ff;

	a_event_gated: assert property (@(posedge clock) disable iff (!reset_n)
		(state_ff == RMC_IDLE && !(cmd_valid && !cmr_ff) && event_valid && !evr_ff && !relationship_info_en)
		|=> state_ff == RMC_IDLE)
		else $error("notice built while feature disabled");
	a_tmo_reject: assert property (@(posedge clock) disable iff (!reset_n)
		(state_ff == RMC_IDLE && cmd_valid && !cmr_ff && cmd_code == `RMC_CMD_TIMEOUT && !tmo_ok)
		|=> tmo_ff == $past(tmo_ff))
		else $error("illegal timeout accepted");
	a_tmo_range: assert property (@(posedge clock) disable iff (!reset_n)
		tmo_ff == 16'h0000 || tmo_ff >= `RMC_TMO_MIN)
		else $error("timeout out of range");
	a_disable_sticky: assert property (@(posedge clock) disable iff (!reset_n)
		!srv_ff |=> !srv_ff)
		else $error("server re-enabled");
	a_notice_code: assert property (@(posedge clock) disable iff (!reset_n)
		(state_ff == RMC_IDLE && nxt_state == RMC_SEND && nxt_hdr[1] == `RMC_INFO_CMD)
		|=> (hdr_ff[2] == `RMC_CMD_ABORT || hdr_ff[2] == `RMC_CMD_OFFLINE) && hdr_ff[3] == 16'h0000
		&& hdr_ff[10] == 16'h0000)
		else $error("bad notice header");
endmodule
`default_nettype wire

// ==== inc/rmc_map.svh ====
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH
// Mailbox header constants.
`define RMC_INFO_CMD 16'h4002
`define RMC_INFO_RSP 16'h0002
`define RMC_INFO_ERR 16'h8002
`define RMC_CMD_ABORT 16'h0118
`define RMC_CMD_OFFLINE 16'h0119
`define RMC_CMD_TIMEOUT 16'h0020
`define RMC_CMD_DISABLE 16'h0021
`define RMC_FRAME_ONE 16'h0001
`define RMC_ZERO_WORD 16'h0000
`define RMC_SIZE_TIMEOUT 16'h0002
// Idle timeout limits and default, seconds.
`define RMC_TMO_DEFAULT 16'h003C
`define RMC_TMO_MIN 16'h000A
// Reason code range.
`define RMC_REASON_MIN 8'h03
`define RMC_REASON_MAX 8'h20
// Timing.
`define RMC_CLK_HZ 20000000
`define RMC_HDR_WORDS 16
`endif

// ==== inc/rmc_pkg.sv ====
package rmc_pkg;
	typedef enum logic [1:0] {
		RMC_IDLE = 2'b00,
		RMC_SEND = 2'b01,
		RMC_WAIT = 2'b10
	} rmc_state_e;
	typedef logic [15:0] rmc_word_t;
endpackage

// ==== hw/rmc_sec_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"
// Divides the clock down to a one-cycle pulse per second.
module rmc_sec_tick
	import rmc_pkg::*;
#(
	parameter int CYCLES = `RMC_CLK_HZ
)
(
	input wire logic clock,
	input wire logic reset_n,
	output logic tick
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic nxt_tick;
	logic tick_ff;

	// Counter wraps at CYCLES and pulses once per wrap.
	always_comb
	begin
		nxt_tick = (cnt_ff == 32'(CYCLES - 1));
		nxt_cnt = nxt_tick ? 32'h0 : cnt_ff + 32'h1;
	end

	// Registers only.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_ff <= 32'h0;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule
`default_nettype wire

// ==== hw/rmc_idle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"
// Watches one server connection and closes it after the idle interval.
module rmc_idle_timer
	import rmc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sec_tick,
	input wire logic conn_open,
	input wire logic conn_request,
	input wire rmc_word_t timeout_sec,
	output logic conn_close
);
	rmc_word_t idle_ff;
	rmc_word_t nxt_idle;
	logic close_ff;
	logic nxt_close;

	// A request restarts the count; zero timeout disables closing.
	always_comb
	begin
		nxt_idle = idle_ff;
		nxt_close = 1'b0;
		if (!conn_open || conn_request)
			nxt_idle = 16'h0000;
		else if (sec_tick && idle_ff != 16'hFFFF)
			nxt_idle = idle_ff + 16'h0001;
		if (conn_open && !conn_request && timeout_sec != 16'h0000 && idle_ff >= timeout_sec)
			nxt_close = 1'b1;
	end

	// Registers only.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			idle_ff <= 16'h0000;
			close_ff <= 1'b0;
		end
		else
		begin
			idle_ff <= nxt_idle;
			close_ff <= nxt_close;
		end
	end

	assign conn_close = close_ff;

	a_idle_close: assert property (@(posedge clock) disable iff (!reset_n)
		conn_close |-> $past(timeout_sec) != 16'h0000)
		else $error("idle close with timeout disabled");
endmodule
`default_nettype wire

// ==== verif/rmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host reader of the outgoing mailbox; it never posts an answer to a notice.
module rmc_host_model
	import rmc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic stall,
	input wire logic mbx_valid,
	input wire rmc_word_t mbx_word,
	input wire logic mbx_last,
	input wire logic [3:0] mbx_index,
	output logic mbx_ready,
	output int msgs,
	output int len,
	output int idx_err
);
	rmc_word_t words [0:19];
	int pos;
	// A stalling host is ready only every other cycle, so the block must hold each word.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mbx_ready <= 1'b0;
			pos <= 0;
			msgs <= 0;
			len <= 0;
			idx_err <= 0;
		end
		else
		begin
			mbx_ready <= stall ? ~mbx_ready : 1'b1;
			if (mbx_valid && mbx_ready)
			begin
				words[pos] <= mbx_word;
				// The index must number each word as it is taken.
				if (mbx_index != 4'(pos))
					idx_err <= idx_err + 1;
				pos <= mbx_last ? 0 : pos + 1;
				if (mbx_last)
				begin
					msgs <= msgs + 1;
					len <= pos + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/relationship_and_modbus_mailbox_cmds_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"
module relationship_and_modbus_mailbox_cmds_tb_top
	import rmc_pkg::*;
;
	logic clock, reset_n, relationship_info_en, event_valid, event_offline, cmd_valid, conn_open, conn_request;
	logic mbx_ready, stall, event_ready, cmd_ready, mbx_valid, mbx_last, server_enabled, conn_close;
	rmc_word_t event_handle, cmd_id, cmd_code, cmd_data, mbx_word, timeout_sec;
	logic [7:0] event_reason;
	logic [3:0] mbx_index;
	int msgs, len, idx_err, err_count, samples_checked;
	rmc_word_t exp [0:16];
	// One second lasts 20 cycles so idle intervals fit a short run.
	rmc_mailbox #(.SEC_CYCLES(20)) rmc_mailbox_inst (.clock(clock), .reset_n(reset_n),
		.relationship_info_en(relationship_info_en), .event_valid(event_valid), .event_offline(event_offline),
		.event_handle(event_handle), .event_reason(event_reason), .cmd_valid(cmd_valid), .cmd_id(cmd_id),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .conn_open(conn_open), .conn_request(conn_request),
		.mbx_ready(mbx_ready), .event_ready(event_ready), .cmd_ready(cmd_ready), .mbx_valid(mbx_valid),
		.mbx_index(mbx_index), .mbx_word(mbx_word), .mbx_last(mbx_last), .server_enabled(server_enabled),
		.timeout_sec(timeout_sec), .conn_close(conn_close));
	rmc_host_model rmc_host_model_inst (.clock(clock), .reset_n(reset_n), .stall(stall), .mbx_valid(mbx_valid),
		.mbx_word(mbx_word), .mbx_last(mbx_last), .mbx_index(mbx_index), .mbx_ready(mbx_ready), .msgs(msgs),
		.len(len), .idx_err(idx_err));
	// Free-running clock.
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task give_verdict;
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task report(input string m);
		err_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task chk_word(input rmc_word_t got, input rmc_word_t want);
		samples_checked++;
		if (got !== want)
			report($sformatf("word %h, wanted %h", got, want));
	endtask
	task chk_flag(input logic got, input logic want);
		samples_checked++;
		if (got !== want)
			report("flag differs");
	endtask
	// Inputs always move 1 ns after an edge.
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task get_msg(input int first, input int hi, input int n);
		int start;
		int i;
		start = msgs;
		for (i = 0; i < 200 && msgs == start; i++) tick(1);
		if (msgs == start)
		begin
			report("no message");
			give_verdict;
		end
		chk_word(16'(len), 16'(n));
		chk_word(16'(idx_err), 16'h0000);
		for (i = first; i <= hi; i++) chk_word(rmc_host_model_inst.words[i], exp[i]);
		if (hi > 2 && n == 17)
			chk_word(rmc_host_model_inst.words[16], exp[16]);
		tick(2);
	endtask
	task send_event(input logic off, input rmc_word_t h, input logic [7:0] r);
		int i;
		event_offline = off;
		event_handle = h;
		event_reason = r;
		event_valid = 1'b1;
		for (i = 0; i < 20 && event_ready !== 1'b1; i++) tick(1);
		chk_flag(event_ready, 1'b1);
		event_valid = 1'b0;
		if (event_ready !== 1'b1)
			give_verdict;
	endtask
	// Words 3, 6, 7 and 10 to 15 must stay zero.
	task notice_case(input logic off, input rmc_word_t h, input logic [7:0] r);
		int i;
		for (i = 6; i < 16; i++) exp[i] = 16'h0000;
		exp[1] = `RMC_INFO_CMD;
		exp[2] = off ? `RMC_CMD_OFFLINE : `RMC_CMD_ABORT;
		exp[3] = 16'h0000;
		exp[4] = 16'h0001;
		exp[5] = 16'h0001;
		exp[6] = 16'h0000;
		exp[7] = 16'h0000;
		exp[8] = h;
		exp[9] = {8'h00, r};
		send_event(off, h, r);
		get_msg(1, 15, 16);
	endtask
	// Commands are only issued while the block is being initialised.
	task reply_case(input rmc_word_t code, input rmc_word_t d, input rmc_word_t info, input int hi, input int n);
		int i;
		for (i = 6; i < 16; i++) exp[i] = 16'h0000;
		exp[0] = cmd_id;
		exp[1] = info;
		exp[2] = code;
		exp[3] = (n == 17) ? 16'h0002 : 16'h0000;
		exp[4] = 16'h0001;
		exp[5] = 16'h0001;
		exp[6] = 16'h0000;
		exp[7] = 16'h0000;
		exp[16] = d;
		cmd_code = code;
		cmd_data = d;
		cmd_valid = 1'b1;
		for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) tick(1);
		chk_flag(cmd_ready, 1'b1);
		cmd_valid = 1'b0;
		if (cmd_ready !== 1'b1)
			give_verdict;
		get_msg(0, hi, n);
	endtask
	// A close must land within a second either side of the interval, as the tick phase is free.
	task idle_case(input int t);
		int i;
		conn_open = 1'b1;
		for (i = 0; i < 1500 && conn_close !== 1'b1; i++) tick(1);
		conn_open = 1'b0;
		if (t == 0)
			chk_flag(conn_close, 1'b0);
		else
			chk_flag(i >= (t - 1) * 20 && i <= (t + 1) * 20 + 5, 1'b1);
		tick(3);
	endtask
	// Main sequence.
	initial
	begin
		{reset_n, relationship_info_en, event_valid, event_offline, cmd_valid, conn_open, conn_request, stall} = '0;
		{event_handle, cmd_code, cmd_data, event_reason} = '0;
		cmd_id = 16'h0011;
		err_count = 0;
		samples_checked = 0;
		tick(10);
		reset_n = 1'b1;
		chk_flag(server_enabled, 1'b1);
		chk_word(timeout_sec, `RMC_TMO_DEFAULT);
		relationship_info_en = 1'b1;
		idle_case(60);
		notice_case(1'b0, 16'h1234, 8'h03);
		stall = 1'b1;
		notice_case(1'b1, 16'hA5C3, 8'h20);
		stall = 1'b0;
		relationship_info_en = 1'b0;
		send_event(1'b0, 16'h0001, 8'h12);
		tick(20);
		chk_word(16'(msgs), 16'h0002);
		relationship_info_en = 1'b1;
		reply_case(`RMC_CMD_TIMEOUT, 16'h000A, `RMC_INFO_RSP, 15, 17);
		idle_case(10);
		stall = 1'b1;
		reply_case(`RMC_CMD_TIMEOUT, 16'h0005, `RMC_INFO_ERR, 15, 17);
		stall = 1'b0;
		chk_word(timeout_sec, 16'h000A);
		reply_case(`RMC_CMD_TIMEOUT, 16'h0000, `RMC_INFO_RSP, 15, 17);
		idle_case(0);
		reply_case(16'h0033, 16'h0000, `RMC_INFO_ERR, 15, 16);
		reply_case(`RMC_CMD_DISABLE, 16'h0000, `RMC_INFO_RSP, 15, 16);
		chk_flag(server_enabled, 1'b0);
		give_verdict;
	end
endmodule
`default_nettype wire
